/* File: src/addr_mode_defines.vh */
`ifndef ADDR_MODE_DEFINES_VH
`define ADDR_MODE_DEFINES_VH
// Addressing mode codes
`define MODE_INHERENT      4'h0
`define MODE_IMMEDIATE     4'h1
`define MODE_DIR_SHORT     4'h2
`define MODE_DIR_LONG      4'h3
`define MODE_IDX_NOOFF     4'h4
`define MODE_IDX_SHORT     4'h5
`define MODE_IDX_LONG      4'h6
`define MODE_IND_SHORT     4'h7
`define MODE_IND_LONG      4'h8
`define MODE_INDIDX_SHORT  4'h9
`define MODE_INDIDX_LONG   4'hA
`define MODE_REL_DIRECT    4'hB
`define MODE_REL_INDIRECT  4'hC
// Instruction groups for long/short legality
`define GRP_LONG_SHORT     2'h0
`define GRP_SHORT_ONLY     2'h1
`define GRP_REL            2'h2
`define GRP_OTHER          2'h3
// Inherent operation codes
`define OP_NONE            2'h0
`define OP_MASK_IRQ        2'h1
`define OP_UNMASK_IRQ      2'h2
// Interrupt mask levels
`define IRQ_LEVEL_MASKED   2'h3
`define IRQ_LEVEL_OPEN     2'h0
`define IRQ_LEVEL_RESET    2'h3
`endif

/* File: src/cpu_addressing_mode_decoder.v */
// What this block does
// - Inherent: single opcode byte, no operands
// - Immediate: one operand byte after opcode
// - Short direct: one address byte, page zero
// - Long direct: two address bytes, full space
// - Indexed: unsigned sum of index and offset
// - No-offset indexed: index alone is address
// - Short indexed: byte offset plus index, to 1FE
// - Long indexed: word offset plus index
// - Indirect: byte names pointer, operand at pointer
// - Short indirect: byte pointer from page zero
// - Long indirect modes: word pointer, full space
// - Indirect indexed: pointer plus index register
// - Short indirect indexed: byte pointer plus index
// - Load/compare/logic/arith allow long and short
// - Memory-modify, jump, call groups: short only
// - Relative: signed byte added to PC
// - Offset inline, or read via page-zero address
// - Offset measured from next instruction
// - Mask op sets interrupt level three
// - Unmask op sets interrupt level zero
// - Short direct and short indirect reach page zero only
`include "addr_mode_defines.vh"
`default_nettype none
module cpu_addressing_mode_decoder #(
  parameter AW = 16
) (
  input  wire          clk_sys_in,
  input  wire          srst_in,
  input  wire          start_in,
  input  wire [3:0]    mode_in,
  input  wire [1:0]    group_in,
  input  wire [1:0]    inh_op_in,
  input  wire          use_y_in,
  input  wire [7:0]    index_x_in,
  input  wire [7:0]    index_y_in,
  input  wire [AW-1:0] pc_in,
  input  wire          mem_valid_in,
  input  wire [7:0]    mem_data_in,
  output reg           mem_rd_out,
  output reg  [AW-1:0] mem_addr_out,
  output reg           done_out,
  output reg           illegal_out,
  output reg  [7:0]    operand_out,
  output reg           operand_valid_out,
  output reg  [AW-1:0] eff_addr_out,
  output reg           eff_addr_valid_out,
  output reg  [AW-1:0] new_pc_out,
  output reg           pc_load_out,
  output reg  [2:0]    length_out,
  output reg  [1:0]    irq_level_out
);

  localparam ST_IDLE  = 3'h0;
  localparam ST_INL1  = 3'h1;
  localparam ST_INL2  = 3'h2;
  localparam ST_PTR1  = 3'h3;
  localparam ST_PTR2  = 3'h4;
  localparam ST_DONE  = 3'h5;

  reg [2:0]    state_reg;
  reg [2:0]    state_next;
  reg [3:0]    mode_reg;
  reg [7:0]    index_reg;
  reg [AW-1:0] fetch_pc_reg;
  reg [7:0]    hi_reg;
  reg [7:0]    ptr_addr_reg;

  wire [7:0] index_sel = use_y_in ? index_y_in : index_x_in;

  // Number of bytes that follow the opcode
  function [1:0] inline_bytes;
    input [3:0] m;
    begin
      case (m)
        `MODE_INHERENT:     inline_bytes = 2'h0;
        `MODE_IMMEDIATE:    inline_bytes = 2'h1;
        `MODE_DIR_SHORT:    inline_bytes = 2'h1;
        `MODE_DIR_LONG:     inline_bytes = 2'h2;
        `MODE_IDX_NOOFF:    inline_bytes = 2'h0;
        `MODE_IDX_SHORT:    inline_bytes = 2'h1;
        `MODE_IDX_LONG:     inline_bytes = 2'h2;
        `MODE_IND_SHORT:    inline_bytes = 2'h1;
        `MODE_IND_LONG:     inline_bytes = 2'h1;
        `MODE_INDIDX_SHORT: inline_bytes = 2'h1;
        `MODE_INDIDX_LONG:  inline_bytes = 2'h1;
        `MODE_REL_DIRECT:   inline_bytes = 2'h1;
        `MODE_REL_INDIRECT: inline_bytes = 2'h1;
        // Unknown codes are refused before this count is ever used
        default:            inline_bytes = 2'h0;
      endcase
    end
  endfunction

  function is_long;
    input [3:0] m;
    begin
      case (m)
        `MODE_DIR_LONG:    is_long = 1'b1;
        `MODE_IDX_LONG:    is_long = 1'b1;
        `MODE_IND_LONG:    is_long = 1'b1;
        `MODE_INDIDX_LONG: is_long = 1'b1;
        default:           is_long = 1'b0;
      endcase
    end
  endfunction

  function is_memref;
    input [3:0] m;
    begin
      is_memref = (m >= `MODE_DIR_SHORT) && (m <= `MODE_INDIDX_LONG);
    end
  endfunction

  function is_rel;
    input [3:0] m;
    begin
      is_rel = (m == `MODE_REL_DIRECT) || (m == `MODE_REL_INDIRECT);
    end
  endfunction

  // Pointer bytes read from page zero after the inline byte
  function [1:0] ptr_bytes;
    input [3:0] m;
    begin
      case (m)
        `MODE_IND_SHORT:    ptr_bytes = 2'h1;
        `MODE_INDIDX_SHORT: ptr_bytes = 2'h1;
        `MODE_REL_INDIRECT: ptr_bytes = 2'h1;
        `MODE_IND_LONG:     ptr_bytes = 2'h2;
        `MODE_INDIDX_LONG:  ptr_bytes = 2'h2;
        default:            ptr_bytes = 2'h0;
      endcase
    end
  endfunction

  // Each refusal reason apart; long forms belong to the load/compare/logic/arith group only
  wire code_unknown  = (mode_in > `MODE_REL_INDIRECT);
  wire long_in_short = is_long(mode_in) && (group_in != `GRP_LONG_SHORT);
  wire mem_in_rel    = is_memref(mode_in) && (group_in == `GRP_REL);
  wire rel_outside   = is_rel(mode_in) && (group_in != `GRP_REL);
  wire mode_bad      = code_unknown || long_in_short || mem_in_rel || rel_outside;

  // Final address for memory-referencing modes, high byte held in hi_reg
  reg [AW-1:0] final_addr;
  always @* begin
    final_addr = {AW{1'b0}};
    case (mode_reg)
      `MODE_DIR_SHORT:    final_addr = {{(AW-8){1'b0}}, mem_data_in};
      `MODE_DIR_LONG:     final_addr = {hi_reg, mem_data_in};
      `MODE_IDX_SHORT:    final_addr = {{(AW-8){1'b0}}, mem_data_in} +
                                       {{(AW-8){1'b0}}, index_reg};
      `MODE_IDX_LONG:     final_addr = {hi_reg, mem_data_in} +
                                       {{(AW-8){1'b0}}, index_reg};
      `MODE_IND_SHORT:    final_addr = {{(AW-8){1'b0}}, mem_data_in};
      `MODE_IND_LONG:     final_addr = {hi_reg, mem_data_in};
      `MODE_INDIDX_SHORT: final_addr = {{(AW-8){1'b0}}, mem_data_in} +
                                       {{(AW-8){1'b0}}, index_reg};
      `MODE_INDIDX_LONG:  final_addr = {hi_reg, mem_data_in} +
                                       {{(AW-8){1'b0}}, index_reg};
      default:            final_addr = {AW{1'b0}};
    endcase
  end

  // Sign-extended offset byte, so a jump reaches 128 back or 127 ahead of the next PC
  wire [AW-1:0] rel_offset = {{(AW-8){mem_data_in[7]}}, mem_data_in};
  // Address after the byte being taken; the relative origin once the last inline byte is in
  wire [AW-1:0] pc_after   = fetch_pc_reg + {{(AW-1){1'b0}}, 1'b1};

  // Offset read from memory: fetch_pc_reg has already moved past the inline byte
  wire [AW-1:0] rel_target = fetch_pc_reg + rel_offset;

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_in && !mode_bad) begin
          if (inline_bytes(mode_in) == 2'h0) begin
            state_next = ST_DONE;
          end else begin
            state_next = ST_INL1;
          end
        end
      end
      ST_INL1: begin
        if (mem_valid_in) begin
          if (inline_bytes(mode_reg) == 2'h2) begin
            state_next = ST_INL2;
          end else if (ptr_bytes(mode_reg) != 2'h0) begin
            state_next = ST_PTR1;
          end else begin
            state_next = ST_DONE;
          end
        end
      end
      ST_INL2: begin
        if (mem_valid_in) begin
          state_next = ST_DONE;
        end
      end
      ST_PTR1: begin
        if (mem_valid_in) begin
          if (ptr_bytes(mode_reg) == 2'h2) begin
            state_next = ST_PTR2;
          end else begin
            state_next = ST_DONE;
          end
        end
      end
      ST_PTR2: begin
        if (mem_valid_in) begin
          state_next = ST_DONE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      state_reg          <= ST_IDLE;
      mode_reg           <= `MODE_INHERENT;
      index_reg          <= 8'h00;
      fetch_pc_reg       <= {AW{1'b0}};
      hi_reg             <= 8'h00;
      ptr_addr_reg       <= 8'h00;
      mem_rd_out         <= 1'b0;
      mem_addr_out       <= {AW{1'b0}};
      done_out           <= 1'b0;
      illegal_out        <= 1'b0;
      operand_out        <= 8'h00;
      operand_valid_out  <= 1'b0;
      eff_addr_out       <= {AW{1'b0}};
      eff_addr_valid_out <= 1'b0;
      new_pc_out         <= {AW{1'b0}};
      pc_load_out        <= 1'b0;
      length_out         <= 3'h0;
      irq_level_out      <= `IRQ_LEVEL_RESET;
    end else begin
      state_reg          <= state_next;
      done_out           <= 1'b0;
      illegal_out        <= 1'b0;
      operand_valid_out  <= 1'b0;
      eff_addr_valid_out <= 1'b0;
      pc_load_out        <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          mem_rd_out <= 1'b0;
          if (start_in) begin
            // A refused start leaves every holding register as it was
            if (mode_bad) begin
              illegal_out <= 1'b1;
            end else begin
              mode_reg     <= mode_in;
              index_reg    <= index_sel;
              fetch_pc_reg <= pc_in;
              length_out   <= {1'b0, inline_bytes(mode_in)} + 3'h1;
              if (mode_in == `MODE_INHERENT) begin
                if (inh_op_in == `OP_MASK_IRQ) begin
                  irq_level_out <= `IRQ_LEVEL_MASKED;
                end else if (inh_op_in == `OP_UNMASK_IRQ) begin
                  irq_level_out <= `IRQ_LEVEL_OPEN;
                end
              end else if (mode_in == `MODE_IDX_NOOFF) begin
                eff_addr_out <= {{(AW-8){1'b0}}, index_sel};
                eff_addr_valid_out <= 1'b1;
              end else begin
                mem_rd_out   <= 1'b1;
                mem_addr_out <= pc_in;
              end
            end
          end
        end
        ST_INL1: begin
          if (mem_valid_in) begin
            fetch_pc_reg <= pc_after;
            hi_reg       <= mem_data_in;
            ptr_addr_reg <= mem_data_in;
            if (state_next == ST_INL2) begin
              mem_addr_out <= pc_after;
            end else if (state_next == ST_PTR1) begin
              mem_addr_out <= {{(AW-8){1'b0}}, mem_data_in};
            end else begin
              mem_rd_out <= 1'b0;
              if (mode_reg == `MODE_IMMEDIATE) begin
                operand_out       <= mem_data_in;
                operand_valid_out <= 1'b1;
              end else if (mode_reg == `MODE_REL_DIRECT) begin
                new_pc_out  <= pc_after + rel_offset;
                pc_load_out <= 1'b1;
              end else begin
                eff_addr_out       <= final_addr;
                eff_addr_valid_out <= 1'b1;
              end
            end
          end
        end
        ST_INL2: begin
          if (mem_valid_in) begin
            mem_rd_out         <= 1'b0;
            fetch_pc_reg       <= fetch_pc_reg + {{(AW-1){1'b0}}, 1'b1};
            eff_addr_out       <= final_addr;
            eff_addr_valid_out <= 1'b1;
          end
        end
        ST_PTR1: begin
          if (mem_valid_in) begin
            hi_reg <= mem_data_in;
            if (state_next == ST_PTR2) begin
              // Wraps inside page zero so a pointer never leaves it
              mem_addr_out <= {{(AW-8){1'b0}}, ptr_addr_reg + 8'h01};
            end else begin
              mem_rd_out <= 1'b0;
              if (mode_reg == `MODE_REL_INDIRECT) begin
                new_pc_out  <= rel_target;
                pc_load_out <= 1'b1;
              end else begin
                eff_addr_out       <= final_addr;
                eff_addr_valid_out <= 1'b1;
              end
            end
          end
        end
        ST_PTR2: begin
          if (mem_valid_in) begin
            mem_rd_out         <= 1'b0;
            eff_addr_out       <= final_addr;
            eff_addr_valid_out <= 1'b1;
          end
        end
        ST_DONE: begin
          // Idle again from this edge, so a new start may be taken on the next one
          done_out <= 1'b1;
        end
        default: begin
          mem_rd_out <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: tb/mem_model.sv */
`default_nettype none
module mem_model (
  input  wire logic        clk_sys_in,
  input  wire logic        rd_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [1:0]  lag_in,
  output var  logic        valid_out,
  output var  logic [7:0]  data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  logic [1:0] wait_cnt = 2'h0;
  initial begin
    valid_out = 1'b0;
    data_out = 8'h00;
  end
  // Skip the edge after a beat so the next address has landed before answering
  always @(posedge clk_sys_in) begin
    valid_out <= 1'b0;
    data_out <= ~data_out;  // Released bus inverts each edge, so it differs from the last byte on the edge after a beat
    if (rd_in && !valid_out) begin
      if (wait_cnt == lag_in) begin
        valid_out <= 1'b1;
        data_out <= mem[addr_in];
        wait_cnt <= 2'h0;
      end else begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/cpu_addressing_mode_decoder_props.sv */
`include "addr_mode_defines.vh"
`default_nettype none
module decoder_props #(parameter int AW = 16) (
  input wire logic          clk_sys_in,
  input wire logic          srst_in,
  input wire logic          start_in,
  input wire logic [3:0]    mode_in,
  input wire logic [1:0]    group_in,
  input wire logic [1:0]    inh_op_in,
  input wire logic          use_y_in,
  input wire logic [7:0]    index_x_in,
  input wire logic [7:0]    index_y_in,
  input wire logic          mem_rd_out,
  input wire logic          done_out,
  input wire logic          illegal_out,
  input wire logic [AW-1:0] eff_addr_out,
  input wire logic          eff_addr_valid_out,
  input wire logic [2:0]    length_out,
  input wire logic [1:0]    irq_level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  int   len_t [13] = '{1, 2, 2, 3, 1, 2, 3, 2, 2, 2, 2, 2, 2};
  logic busy_reg;
  logic [3:0] mode_reg;
  wire  acc = start_in && !busy_reg;
  always @(posedge clk_sys_in) begin
    if (srst_in) busy_reg <= 1'b0;
    else if (acc) busy_reg <= 1'b1;
    else if (done_out || illegal_out) busy_reg <= 1'b0;
    if (acc) mode_reg <= mode_in;
  end
  a_len_at_done: assert property (done_out |-> length_out == 3'(len_t[mode_reg]))
    else $error("length wrong at done");
  a_inh_no_read: assert property (acc && mode_in == `MODE_INHERENT
    |=> !mem_rd_out ##1 (done_out && !mem_rd_out)) else $error("inherent read memory");
  a_mask_level: assert property (acc && mode_in == `MODE_INHERENT
    && inh_op_in == `OP_MASK_IRQ |=> irq_level_out == 2'h3) else $error("mask level wrong");
  a_unmask_level: assert property (acc && mode_in == `MODE_INHERENT
    && inh_op_in == `OP_UNMASK_IRQ |=> irq_level_out == 2'h0) else $error("unmask level wrong");
  a_nooff_addr: assert property (acc && mode_in == `MODE_IDX_NOOFF
    && group_in != `GRP_REL |=> eff_addr_valid_out
    && eff_addr_out == AW'($past(use_y_in) ? $past(index_y_in) : $past(index_x_in)))
    else $error("no-offset address wrong");
  a_long_refused: assert property (acc && group_in == `GRP_SHORT_ONLY && mode_in inside
    {`MODE_DIR_LONG, `MODE_IDX_LONG, `MODE_IND_LONG, `MODE_INDIDX_LONG}
    |=> illegal_out && !mem_rd_out) else $error("long form accepted");
  a_both_forms: assert property (acc && group_in == `GRP_LONG_SHORT
    && mode_in inside {[`MODE_DIR_SHORT:`MODE_INDIDX_LONG]} |=> !illegal_out)
    else $error("legal form refused");
  a_rel_group: assert property (acc && mode_in inside {`MODE_REL_DIRECT, `MODE_REL_INDIRECT}
    && group_in != `GRP_REL |=> illegal_out) else $error("relative group accepted");
  a_short_page: assert property (eff_addr_valid_out && mode_reg inside
    {`MODE_DIR_SHORT, `MODE_IND_SHORT} |-> eff_addr_out[AW-1:8] == '0)
    else $error("short mode left page zero");
endmodule
bind cpu_addressing_mode_decoder decoder_props #(.AW(AW)) u_decoder_props (.clk_sys_in, .srst_in,
  .start_in, .mode_in, .group_in, .inh_op_in, .use_y_in, .index_x_in, .index_y_in, .mem_rd_out,
  .done_out, .illegal_out, .eff_addr_out, .eff_addr_valid_out, .length_out, .irq_level_out);
`default_nettype wire

/* File: tb/test_cpu_addressing_mode_decoder.sv */
`include "addr_mode_defines.vh"
`default_nettype none
module test_cpu_addressing_mode_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_in, srst_in, start_in, use_y_in, mem_valid_in, mem_rd_out, done_out;
  logic        illegal_out, operand_valid_out, eff_addr_valid_out, pc_load_out;
  logic [1:0]  group_in, inh_op_in, irq_level_out, lag;
  logic [2:0]  length_out;
  logic [3:0]  mode_in;
  logic [7:0]  index_x_in, index_y_in, mem_data_in, operand_out;
  logic [15:0] pc_in, mem_addr_out, eff_addr_out, new_pc_out;
  int          failures = 0, check_count = 0, lvl = 3;
  int          len_t [13] = '{1, 2, 2, 3, 1, 2, 3, 2, 2, 2, 2, 2, 2};
  int          sh [5] = '{2, 4, 5, 7, 9};
  int          lg [4] = '{3, 6, 8, 10};
  cpu_addressing_mode_decoder #(.AW(16)) u_cpu_addressing_mode_decoder (.clk_sys_in, .srst_in,
    .start_in, .mode_in, .group_in, .inh_op_in, .use_y_in, .index_x_in, .index_y_in, .pc_in,
    .mem_valid_in, .mem_data_in, .mem_rd_out, .mem_addr_out, .done_out, .illegal_out,
    .operand_out, .operand_valid_out, .eff_addr_out, .eff_addr_valid_out, .new_pc_out,
    .pc_load_out, .length_out, .irq_level_out);
  mem_model u_mem_model (.clk_sys_in, .rd_in(mem_rd_out), .addr_in(mem_addr_out), .lag_in(lag),
    .valid_out(mem_valid_in), .data_out(mem_data_in));
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    if (failures == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  function automatic logic [1:0] grp(int m);
    return m == 0 ? `GRP_OTHER : m > 10 ? `GRP_REL : `GRP_LONG_SHORT;
  endfunction
  task automatic run(input int m, input logic [1:0] g, input int op, input bit bad);
    int pc, ix, b0, b1, q0, q1, e;
    bit seen = 0, ill = 0, dn = 0, uy;
    logic [7:0] x, y;
    @(posedge clk_sys_in);
    pc = $urandom % 65536;
    x = 8'($urandom);
    y = 8'($urandom);
    uy = 1'($urandom);
    ix = uy ? y : x;
    mode_in <= 4'(m);
    group_in <= g;
    inh_op_in <= 2'(op);
    pc_in <= 16'(pc);
    index_x_in <= x;
    index_y_in <= y;
    use_y_in <= uy;
    lag <= 2'($urandom);
    start_in <= 1'b1;
    b0 = u_mem_model.mem[pc];
    b1 = u_mem_model.mem[(pc + 1) % 65536];
    q0 = u_mem_model.mem[b0];
    q1 = u_mem_model.mem[(b0 + 1) % 256];
    case (m)
      0: lvl = op == 1 ? 3 : op == 2 ? 0 : lvl;
      1, 2: e = b0;
      3: e = b0 * 256 + b1;
      4: e = ix;
      5: e = b0 + ix;
      6: e = b0 * 256 + b1 + ix;
      7: e = q0;
      8: e = q0 * 256 + q1;
      9: e = q0 + ix;
      10: e = q0 * 256 + q1 + ix;
      11: e = pc + 1 + (b0 ^ 128) - 128;
      default: e = pc + 1 + (q0 ^ 128) - 128;
    endcase
    @(posedge clk_sys_in);
    start_in <= 1'b0;
    // Look right after the accepting edge too: a refusal or a one-cycle result stands only then
    for (int i = 0; i < 40 && !dn && !ill; i++) begin
      #1;
      dn = done_out === 1'b1;
      ill = illegal_out === 1'b1;
      seen |= (m == 1 ? operand_valid_out : m > 10 ? pc_load_out : eff_addr_valid_out) === 1'b1;
      @(posedge clk_sys_in);
    end
    if (bad) begin
      chk(16'({ill, dn}), 16'h0002);
    end else begin
      chk(16'({ill, dn, seen || m == 0}), 16'h0003);
      chk(16'(length_out), 16'(len_t[m]));
      if (m == 0) chk(16'(irq_level_out), 16'(lvl));
      else if (m == 1) chk(16'(operand_out), 16'(e));
      else if (m > 10) chk(new_pc_out, 16'(e));
      else chk(eff_addr_out, 16'(e));
    end
  endtask
  initial begin
    #100us;
    failures++;
    conclude();
  end
  initial begin
    {srst_in, start_in, use_y_in, group_in, inh_op_in, lag, mode_in} = '1;
    {index_x_in, index_y_in, pc_in} = '0;
    start_in = 1'b0;
    void'($urandom(61));
    for (int a = 0; a < 65536; a++) u_mem_model.mem[a] = 8'($urandom);
    repeat (4) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    #1;
    chk(16'(irq_level_out), 16'h0003);
    run(0, `GRP_OTHER, 2, 0);
    run(0, `GRP_OTHER, 1, 0);
    for (int m = 0; m < 13; m++) run(m, grp(m), 0, 0);
    foreach (sh[i]) run(sh[i], `GRP_SHORT_ONLY, 0, 0);
    foreach (lg[i]) run(lg[i], `GRP_SHORT_ONLY, 0, 1);
    run(11, `GRP_LONG_SHORT, 0, 1);
    run(2, `GRP_REL, 0, 1);
    run(13, `GRP_LONG_SHORT, 0, 1);
    run(0, `GRP_OTHER, 2, 0);
    srst_in <= 1'b1;
    @(posedge clk_sys_in);
    srst_in <= 1'b0;
    lvl = 3;
    #1;
    chk(16'(irq_level_out), 16'h0003);
    repeat (60) begin
      int m;
      m = $urandom % 13;
      run(m, grp(m), $urandom % 3, 0);
    end
    conclude();
  end
endmodule
`default_nettype wire
